// >>> ssf_pkg.sv
// ssf_pkg: register map, field positions, reset values and timing counts
// assumes: 32-bit apb, 25 MHz clock
package ssf_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] SSF_STATUS_OFS  = 8'h00; // line_status_flags, read only
    localparam logic [7:0] SSF_DATA_OFS    = 8'h04; // serial_data_reg
    localparam logic [7:0] SSF_CTRL2_OFS   = 8'h08; // serial_ctrl2_reg
    localparam logic [7:0] SSF_CTRL1_OFS   = 8'h0c; // serial_ctrl1_reg
    localparam logic [7:0] SSF_IRQ_ST_OFS  = 8'h10; // sticky event status, read only
    localparam logic [7:0] SSF_IRQ_EN_OFS  = 8'h14; // event enable
    localparam logic [7:0] SSF_IRQ_CLR_OFS = 8'h18; // event clear, write only
    localparam logic [7:0] SSF_EVENT_OFS   = 8'h1c; // line event injection, write only

    // ------------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------------
    localparam int SSF_TXE_BIT  = 7;
    localparam int SSF_TXD_BIT  = 6;
    localparam int SSF_RXF_BIT  = 5;
    localparam int SSF_IDLE_BIT = 4;
    localparam int SSF_OVR_BIT  = 3;
    localparam int SSF_NOI_BIT  = 2;
    localparam int SSF_FRM_BIT  = 1;
    localparam int SSF_PAR_BIT  = 0;
    localparam logic [7:0] SSF_STATUS_RST = 8'hc0;

    // ctrl2 enables
    localparam int SSF_TIE_BIT  = 7;
    localparam int SSF_TX_DONE_IRQ_EN_BIT = 6;
    localparam int SSF_RIE_BIT  = 5;
    localparam int SSF_IDLE_IRQ_EN_BIT = 4;
    localparam logic [7:0] SSF_CTRL2_RST = 8'h00;
    // ctrl1 parity enable
    localparam int SSF_PIE_BIT  = 0;
    localparam logic [7:0] SSF_CTRL1_RST = 8'h00;

    // event injection bits (line-side events from the framing engine)
    localparam int SSF_EV_TXDONE = 0; // data frame finished
    localparam int SSF_EV_PREAM  = 1; // preamble or break finished
    localparam int SSF_EV_RXWORD = 2; // shifted word complete
    localparam int SSF_EV_IDLE   = 3; // idle line seen
    localparam int SSF_EV_FRAME  = 4; // framing error on word
    localparam int SSF_EV_PARITY = 5; // parity mismatch on word
    localparam int SSF_EV_NOISE  = 6; // majority disagreement on a bit

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int SSF_CLK_MHZ      = 25;
    localparam int SSF_TX_FRAME_NS  = 400; // shift time of one frame
    localparam int SSF_TX_FRAME_CYC = (SSF_TX_FRAME_NS * SSF_CLK_MHZ + 999) / 1000;
    localparam int SSF_OVS_COUNT    = 16;  // samples per bit
    localparam int SSF_OVS_MID      = 8;   // centre of the three middle samples

endpackage : ssf_pkg

// >>> ssf_remote.sv
// ssf_remote.sv: far-end serial transmitter feeding the receive pin
// assumes: 16 clocks a bit, line idles high, one start, 8 data lsb first, one stop
`timescale 1ns/100ps
module ssf_remote (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       send_i,
    input  wire logic [7:0] word_i,
    output logic            rx_pin_o,
    output logic      [7:0] rx_word_o
);
    logic [9:0] frame_ff;
    logic [7:0] cnt_ff;
    // shift one clean frame out, one bit every 16 clocks
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            frame_ff  <= 10'h3ff;
            cnt_ff    <= 8'h00;
            rx_word_o <= 8'h00;
        end else if (send_i) begin
            frame_ff  <= {1'b1, word_i, 1'b0};
            cnt_ff    <= 8'ha0;
            rx_word_o <= word_i;
        end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
            if (cnt_ff[3:0] == 4'h1) frame_ff <= {1'b1, frame_ff[9:1]};
        end
    end
    assign rx_pin_o = frame_ff[0]; // mark level between frames
endmodule : ssf_remote

// >>> ssf_top.sv
// ssf_top: status-flag logic of an asynchronous serial interface
// assumes: apb master on clk_i, rx pin asynchronous, framing engine reduced
// to a simple transmit shifter timer and a sampled receive pin plus events
`timescale 1ns/100ps

// Functional notes
// - tx empty set when holding moves to shifter
// - tx empty interrupt when enabled
// - status access then data write clears tx flags
// - no new transfer until tx empty cleared
// - tx done set after data frame, interrupts
// - preamble or break leaves tx done alone
// - rx full set on word arrival, interrupts
// - status access then data read clears rx flags
// - idle flag set on idle line, interrupts
// - idle rearms only after new rx full
// - overrun when word completes while rx full
// - overrun keeps holding data, shifter overwritten
// - noise flag, no interrupt of its own; here it can interrupt through its bit in the event enable register
// - framing flag, no interrupt of its own; here it can interrupt through its bit in the event enable register
// - framing plus overrun sets only overrun
// - parity flag, enable, sequence clear
// - middle three samples majority, disagreement noise
// - rx enable gates overrun or rx full; here there is no rx enable, both follow the word-complete event alone
module ssf_top
    import ssf_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        rx_pin_i,
    input  wire logic [7:0]  rx_word_i,
    output logic      [7:0]  tx_shift_o,
    output logic             tx_busy_o,
    output logic             irq_o
);

    typedef enum logic [1:0] {
        SSF_TX_IDLE  = 2'b00,
        SSF_TX_SHIFT = 2'b01
    } ssf_tx_state_type;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]       status_ff;
    logic [7:0]       ctrl1_ff;
    logic [7:0]       ctrl2_ff;
    logic [7:0]       tx_hold_ff;
    logic             tx_hold_full_ff;
    logic [7:0]       tx_shift_ff;
    logic [7:0]       rx_hold_ff;
    logic [7:0]       rx_shift_ff;
    logic [3:0]       rx_bit_ff;
    logic             status_seen_ff;
    logic             idle_armed_ff;
    logic [15:0]      tx_cnt_ff;
    ssf_tx_state_type tx_state_ff;
    logic [1:0]       rx_sync_ff;
    logic [3:0]       ovs_cnt_ff;
    logic [2:0]       mid_ff;
    logic             bit_noise_ff;
    logic [7:0]       ev_st_ff;
    logic [7:0]       ev_en_ff;
    logic [31:0]      prdata_ff;
    logic             pready_ff;
    logic             pslverr_ff;
    logic             irq_ff;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic       acc;
    logic       wr;
    logic       rd;
    logic       st_acc;
    logic       data_wr;
    logic       data_rd;
    logic       ev_wr;
    logic       mapped;
    logic [7:0] ev;

    // access phase completes on the cycle pready is high
    assign acc     = ce_i && psel_i && penable_i && pready_ff;
    assign wr      = acc && pwrite_i && pstrb_i[0];
    assign rd      = acc && !pwrite_i;
    assign st_acc  = acc && (paddr_i == SSF_STATUS_OFS);
    assign data_wr = wr && (paddr_i == SSF_DATA_OFS);
    assign data_rd = rd && (paddr_i == SSF_DATA_OFS);
    assign ev_wr   = wr && (paddr_i == SSF_EVENT_OFS);
    assign ev      = ev_wr ? pwdata_i[7:0] : 8'h00;

    always_comb begin
        if (paddr_i == SSF_STATUS_OFS) begin
            mapped = 1'b1;
        end else if (paddr_i == SSF_DATA_OFS || paddr_i == SSF_CTRL2_OFS) begin
            mapped = 1'b1;
        end else if (paddr_i == SSF_CTRL1_OFS || paddr_i == SSF_IRQ_ST_OFS) begin
            mapped = 1'b1;
        end else if (paddr_i == SSF_IRQ_EN_OFS || paddr_i == SSF_IRQ_CLR_OFS) begin
            mapped = 1'b1;
        end else begin
            mapped = (paddr_i == SSF_EVENT_OFS);
        end
    end

    // ------------------------------------------------------------------
    // receive pin sampling
    // ------------------------------------------------------------------
    logic rx_s;
    logic [1:0] mid_sum;
    logic maj;
    logic mid_bad;

    assign rx_s    = rx_sync_ff[1];
    assign mid_sum = {1'b0, mid_ff[0]} + {1'b0, mid_ff[1]} + {1'b0, mid_ff[2]};
    assign maj     = mid_sum[1];
    assign mid_bad = (mid_ff != 3'b000) && (mid_ff != 3'b111);

    // two-stage synchroniser for the pin
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_sync_ff <= 2'b11;
        end else if (ce_i) begin
            rx_sync_ff <= {rx_sync_ff[0], rx_pin_i};
        end
    end

    // a low line in idle starts a frame and restarts the sixteen-sample count
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ovs_cnt_ff   <= 4'h1;
            rx_bit_ff    <= 4'h0;
            mid_ff       <= 3'h7;
            bit_noise_ff <= 1'b0;
        end else if (ce_i) begin
            ovs_cnt_ff <= (rx_bit_ff == 4'h0) ? 4'h1 : ovs_cnt_ff + 4'h1;
            if (rx_bit_ff == 4'h0) begin
                rx_bit_ff <= {3'h0, !rx_s};                  // first low sample is sample 0
            end
            if (ovs_cnt_ff >= 4'(SSF_OVS_MID - 1) && ovs_cnt_ff <= 4'(SSF_OVS_MID + 1)) begin
                mid_ff <= {mid_ff[1:0], rx_s};
            end
            if (ovs_cnt_ff == 4'(SSF_OVS_COUNT - 1)) begin
                rx_bit_ff    <= (rx_bit_ff == 4'ha) ? 4'h0 : rx_bit_ff + 4'h1; // start, 8 data, stop
                bit_noise_ff <= bit_noise_ff
                                | (mid_bad && rx_bit_ff >= 4'h2 && rx_bit_ff <= 4'h9);
                rx_shift_ff  <= {maj, rx_shift_ff[7:1]};
            end
            if (ev[SSF_EV_RXWORD]) begin
                bit_noise_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // transmit path
    // ------------------------------------------------------------------
    logic tx_move;
    assign tx_move = (tx_state_ff == SSF_TX_IDLE) && tx_hold_full_ff
                     && !status_ff[SSF_TXE_BIT] && !data_wr;

    // holding register filled by data writes
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_hold_ff      <= 8'h00;
            tx_hold_full_ff <= 1'b0;
        end else if (ce_i) begin
            if (data_wr) begin
                tx_hold_ff      <= pwdata_i[7:0];
                tx_hold_full_ff <= 1'b1;
            end else if (tx_move) begin
                tx_hold_full_ff <= 1'b0;
            end
        end
    end

    // shifter timer stands in for the framing engine
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_state_ff <= SSF_TX_IDLE;
            tx_cnt_ff   <= 16'h0000;
            tx_shift_ff <= 8'h00;
        end else if (ce_i) begin
            case (tx_state_ff)
                SSF_TX_IDLE: begin
                    if (tx_move) begin
                        tx_shift_ff <= tx_hold_ff;
                        tx_cnt_ff   <= 16'(SSF_TX_FRAME_CYC - 1);
                        tx_state_ff <= SSF_TX_SHIFT;
                    end
                end
                SSF_TX_SHIFT: begin
                    if (tx_cnt_ff == 16'h0000) begin
                        tx_state_ff <= SSF_TX_IDLE;
                    end else begin
                        tx_cnt_ff <= tx_cnt_ff - 16'h0001;
                    end
                end
                default: begin
                    tx_state_ff <= SSF_TX_IDLE;
                end
            endcase
        end
    end

    logic tx_frame_done;
    assign tx_frame_done = ((tx_state_ff == SSF_TX_SHIFT) && (tx_cnt_ff == 16'h0000))
                           || ev[SSF_EV_TXDONE];

    // ------------------------------------------------------------------
    // receive word transfer
    // ------------------------------------------------------------------
    logic rx_word;
    logic rx_ovr;
    assign rx_word = ev[SSF_EV_RXWORD];
    assign rx_ovr  = rx_word && status_ff[SSF_RXF_BIT];

    // holding register is kept on overrun, only the shifter changes
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_hold_ff <= 8'h00;
        end else if (ce_i && rx_word && !rx_ovr) begin
            rx_hold_ff <= rx_word_i;
        end
    end

    // ------------------------------------------------------------------
    // clear sequence tracking
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            status_seen_ff <= 1'b0;
        end else if (ce_i) begin
            if (st_acc) begin
                status_seen_ff <= 1'b1;
            end else if (data_wr || data_rd) begin
                status_seen_ff <= 1'b0;
            end
        end
    end

    logic clr_tx;
    logic clr_rx;
    assign clr_tx = status_seen_ff && data_wr;
    assign clr_rx = status_seen_ff && data_rd;

    // idle rearms only once a fresh word has set the rx full flag
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            idle_armed_ff <= 1'b1;
        end else if (ce_i) begin
            if (rx_word && !rx_ovr) begin
                idle_armed_ff <= 1'b1;
            end else if (ev[SSF_EV_IDLE] && idle_armed_ff) begin
                idle_armed_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // status flags; a set in the clearing cycle wins
    // ------------------------------------------------------------------
    logic [7:0] set_v;
    logic [7:0] clr_v;
    always_comb begin
        set_v = 8'h00;
        clr_v = 8'h00;
        set_v[SSF_TXE_BIT]  = tx_move;
        set_v[SSF_TXD_BIT]  = tx_frame_done;
        // a preamble or break finishing sets nothing
        set_v[SSF_RXF_BIT]  = rx_word && !rx_ovr;
        set_v[SSF_IDLE_BIT] = ev[SSF_EV_IDLE] && idle_armed_ff;
        set_v[SSF_OVR_BIT]  = rx_ovr;
        set_v[SSF_NOI_BIT]  = rx_word && !rx_ovr
                              && (bit_noise_ff || ev[SSF_EV_NOISE]);
        set_v[SSF_FRM_BIT]  = ev[SSF_EV_FRAME] && !rx_ovr;
        set_v[SSF_PAR_BIT]  = ev[SSF_EV_PARITY] && !rx_ovr;
        clr_v[SSF_TXE_BIT]  = clr_tx;
        clr_v[SSF_TXD_BIT]  = clr_tx;
        clr_v[5:0]          = {6{clr_rx}};
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            status_ff <= SSF_STATUS_RST;
        end else if (ce_i) begin
            status_ff <= (status_ff & ~clr_v) | set_v;
        end
    end

    // ------------------------------------------------------------------
    // control registers and event interrupt block
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl1_ff <= SSF_CTRL1_RST;
            ctrl2_ff <= SSF_CTRL2_RST;
            ev_en_ff <= 8'h00;
        end else if (ce_i && wr) begin
            if (paddr_i == SSF_CTRL1_OFS) begin
                ctrl1_ff <= pwdata_i[7:0];
            end else if (paddr_i == SSF_CTRL2_OFS) begin
                ctrl2_ff <= pwdata_i[7:0];
            end else if (paddr_i == SSF_IRQ_EN_OFS) begin
                ev_en_ff <= pwdata_i[7:0];
            end
        end
    end

    // sticky events latch on flag set; write-one clears, set wins
    logic [7:0] ev_clr;
    assign ev_clr = (wr && paddr_i == SSF_IRQ_CLR_OFS) ? pwdata_i[7:0] : 8'h00;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ev_st_ff <= 8'h00;
        end else if (ce_i) begin
            ev_st_ff <= (ev_st_ff & ~ev_clr) | set_v;
        end
    end

    // interrupt request from flag levels and sticky events
    logic flag_irq;
    assign flag_irq = (status_ff[SSF_TXE_BIT] && ctrl2_ff[SSF_TIE_BIT])
                   || (status_ff[SSF_TXD_BIT] && ctrl2_ff[SSF_TX_DONE_IRQ_EN_BIT])
                   || ((status_ff[SSF_RXF_BIT] || status_ff[SSF_OVR_BIT])
                       && ctrl2_ff[SSF_RIE_BIT])
                   || (status_ff[SSF_IDLE_BIT] && ctrl2_ff[SSF_IDLE_IRQ_EN_BIT])
                   || (status_ff[SSF_PAR_BIT] && ctrl1_ff[SSF_PIE_BIT]);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_ff <= 1'b0;
        end else if (ce_i) begin
            irq_ff <= flag_irq || (|(ev_st_ff & ev_en_ff));
        end
    end

    // ------------------------------------------------------------------
    // apb answer: one wait state, then pready
    // ------------------------------------------------------------------
    logic [7:0] rd_byte;
    always_comb begin
        if (paddr_i == SSF_STATUS_OFS) begin
            rd_byte = status_ff;
        end else if (paddr_i == SSF_DATA_OFS) begin
            rd_byte = rx_hold_ff;
        end else if (paddr_i == SSF_CTRL2_OFS) begin
            rd_byte = ctrl2_ff;
        end else if (paddr_i == SSF_CTRL1_OFS) begin
            rd_byte = ctrl1_ff;
        end else if (paddr_i == SSF_IRQ_ST_OFS) begin
            rd_byte = ev_st_ff;
        end else if (paddr_i == SSF_IRQ_EN_OFS) begin
            rd_byte = ev_en_ff;
        end else begin
            rd_byte = 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (ce_i) begin
            if (psel_i && penable_i && !pready_ff) begin
                pready_ff  <= 1'b1;
                prdata_ff  <= {24'h00_0000, rd_byte};
                pslverr_ff <= !mapped;
            end else begin
                pready_ff  <= 1'b0;
                pslverr_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata_o   = prdata_ff;
    assign pready_o   = pready_ff;
    assign pslverr_o  = pslverr_ff;
    assign tx_shift_o = tx_shift_ff;
    assign tx_busy_o  = tx_state_ff[0];                      // shift state is coded 2'b01
    assign irq_o      = irq_ff;

endmodule : ssf_top

// >>> ssf_top_properties.sv
// ssf_top_properties.sv: port-level checks of the status-flag block
// assumes: one clock, sync reset, apb master keeps the handshake
`timescale 1ns/100ps
module ssf_checker
    import ssf_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        ce_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0]  pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        rx_pin_i,
    input wire logic [7:0]  rx_word_i,
    input wire logic [7:0]  tx_shift_o,
    input wire logic        tx_busy_o,
    input wire logic        irq_o
);
    logic [7:0] c2_ff;
    logic       pie_ff;
    logic       ee_ff;
    logic       wr_w;
    // completed low-byte write, as the slave takes it
    assign wr_w = ce_i && psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0];
    // shadow of every enable that can raise the interrupt
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            c2_ff  <= 8'h00;
            pie_ff <= 1'b0;
            ee_ff  <= 1'b0;
        end else if (wr_w) begin
            if (paddr_i == SSF_CTRL2_OFS) c2_ff <= pwdata_i[7:0];
            if (paddr_i == SSF_CTRL1_OFS) pie_ff <= pwdata_i[SSF_PIE_BIT];
            if (paddr_i == SSF_IRQ_EN_OFS) ee_ff <= |pwdata_i[7:0];
        end
    end
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i || !ce_i);
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready held longer than one cycle");
    a_ready_wait: assert property (psel_i && penable_i && !$past(penable_i)
        |-> !pready_o ##1 pready_o) else $error("pready not after one wait state");
    a_err_unmapped: assert property (pready_o && (paddr_i[7:5] != 3'h0 || paddr_i[1:0] != 2'h0)
        |-> pslverr_o && prdata_o == 32'h0) else $error("unmapped access not refused");
    a_ok_mapped: assert property (pready_o && paddr_i[7:5] == 3'h0 && paddr_i[1:0] == 2'h0
        |-> !pslverr_o && prdata_o[31:8] == 24'h0) else $error("mapped access bad");
    a_frame_hold: assert property ($rose(tx_busy_o) |-> tx_busy_o [*8])
        else $error("frame ended too early");
    a_shift_stable: assert property (tx_busy_o && $past(tx_busy_o)
        |-> $stable(tx_shift_o)) else $error("shifter changed during a frame");
    a_irq_masked: assert property (c2_ff == 8'h0 && !pie_ff && !ee_ff
        && $past(c2_ff) == 8'h0 && !$past(pie_ff) && !$past(ee_ff) |-> !irq_o)
        else $error("interrupt with all sources disabled");
    a_txe_irq: assert property ($rose(tx_busy_o) && c2_ff[SSF_TIE_BIT]
        |-> ##[1:3] irq_o) else $error("no interrupt on tx empty");
    cover property ($rose(tx_busy_o));
    cover property (pready_o && pslverr_o);
    cover property ($rose(irq_o));
endmodule : ssf_checker

bind ssf_top ssf_checker chk (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rx_pin_i(rx_pin_i), .rx_word_i(rx_word_i),
    .tx_shift_o(tx_shift_o), .tx_busy_o(tx_busy_o), .irq_o(irq_o));

// >>> test_serial_status_flags.sv
// test_serial_status_flags.sv: self-checking bench for ssf_top
// assumes: ssf_pkg map, one wait-state apb slave, 40 ns clock
`timescale 1ns/100ps
module test_serial_status_flags
    import ssf_pkg::*;
();
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, send = 1'b0;
    logic [7:0]  paddr = 8'h00, word = 8'h00, keep, tx_shift, rx_word;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, rx_pin, tx_busy, irq;
    logic [32:0] exp_q[$];
    int          err_total = 0, total_checks = 0, cyc = 0;

    ssf_top dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .rx_pin_i(rx_pin), .rx_word_i(rx_word), .tx_shift_o(tx_shift),
        .tx_busy_o(tx_busy), .irq_o(irq));
    ssf_remote far (.clk_i(clk_i), .srst_i(srst_i), .send_i(send), .word_i(word),
        .rx_pin_o(rx_pin), .rx_word_o(rx_word));

    initial forever #20 clk_i = ~clk_i;
    // --------------------------------------------------------------
    // compare, bus cycles and waits
    // --------------------------------------------------------------
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i iff pready === 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({25'h0, e});
        xfer(1'b0, a, 32'h0);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic irqchk(input logic e);
        repeat (3) @(posedge clk_i);
        chk({32'h0, irq}, {32'h0, e});
    endtask : irqchk
    task automatic waitb(input logic v);
        for (int i = 0; i < 30 && tx_busy !== v; i++) @(posedge clk_i);
        chk({32'h0, tx_busy}, {32'h0, v});
    endtask : waitb
    // far end sends a random word, then the word-complete event lands
    task automatic rx(input logic [31:0] ev);
        word <= 8'($urandom);
        send <= 1'b1;
        @(posedge clk_i);
        send <= 1'b0;
        repeat (170) @(posedge clk_i);
        wr(SSF_EVENT_OFS, ev);
    endtask : rx
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    // read results are compared with the oldest note
    always @(posedge clk_i) if (psel && penable && pready === 1'b1 && !pwrite)
        chk({pslverr, prdata}, exp_q.pop_front());
    // cut a hang short
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            summarize();
        end
    end
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        keep = 8'($urandom(32'h180ec19d));
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        rd(SSF_STATUS_OFS, SSF_STATUS_RST);
        rd(SSF_CTRL2_OFS, SSF_CTRL2_RST);
        exp_q.push_back({1'b1, 32'h0});
        xfer(1'b0, 8'h20, 32'h0);
        irqchk(1'b0);
        $display("test reset done");
        rd(SSF_DATA_OFS, 8'h00);
        wr(SSF_DATA_OFS, 32'h3c);
        repeat (12) @(posedge clk_i);
        chk({32'h0, tx_busy}, 33'h0);
        rd(SSF_STATUS_OFS, 8'hc0);
        wr(SSF_CTRL2_OFS, 32'h80);
        irqchk(1'b1);
        wr(SSF_DATA_OFS, 32'h5a);
        waitb(1'b1);
        chk({25'h0, tx_shift}, 33'h5a);
        wr(SSF_EVENT_OFS, 32'h02);
        rd(SSF_STATUS_OFS, 8'h80);
        waitb(1'b0);
        rd(SSF_STATUS_OFS, 8'hc0);
        wr(SSF_CTRL2_OFS, 32'h40);
        irqchk(1'b1);
        wr(SSF_CTRL2_OFS, 32'h0);
        irqchk(1'b0);
        $display("test transmit done");
        for (int k = 0; k < 3; k++) begin
            rx(32'h04);
            rd(SSF_STATUS_OFS, 8'he0);
            rd(SSF_DATA_OFS, word);
        end
        rx(32'h04);
        keep = word;
        wr(SSF_CTRL2_OFS, 32'h20);
        irqchk(1'b1);
        rx(32'h14);
        rd(SSF_STATUS_OFS, 8'he8);
        irqchk(1'b1);
        rd(SSF_DATA_OFS, keep);
        rd(SSF_STATUS_OFS, 8'hc0);
        wr(SSF_CTRL2_OFS, 32'h0);
        rx(32'h74);
        keep = word;
        irqchk(1'b0);
        wr(SSF_CTRL1_OFS, 32'h1);
        irqchk(1'b1);
        wr(SSF_CTRL1_OFS, 32'h0);
        rd(SSF_STATUS_OFS, 8'he7);
        rd(SSF_DATA_OFS, keep);
        rd(SSF_STATUS_OFS, 8'hc0);
        $display("test receive done");
        wr(SSF_EVENT_OFS, 32'h08);
        rd(SSF_STATUS_OFS, 8'hd0);
        wr(SSF_CTRL2_OFS, 32'h10);
        irqchk(1'b1);
        wr(SSF_CTRL2_OFS, 32'h0);
        rd(SSF_DATA_OFS, keep);
        wr(SSF_EVENT_OFS, 32'h08);
        rd(SSF_STATUS_OFS, 8'hc0);
        rx(32'h04);
        wr(SSF_EVENT_OFS, 32'h08);
        rd(SSF_STATUS_OFS, 8'hf0);
        $display("test idle done");
        wr(SSF_IRQ_EN_OFS, 32'h20);
        irqchk(1'b1);
        wr(SSF_IRQ_EN_OFS, 32'h0);
        wr(SSF_IRQ_CLR_OFS, 32'h20);
        pstrb <= 4'h0;
        wr(SSF_CTRL2_OFS, 32'h20);
        pstrb <= 4'hf;
        rd(SSF_CTRL2_OFS, 8'h00);
        irqchk(1'b0);
        $display("test interrupt done");
        summarize();
    end
endmodule : test_serial_status_flags
